// >>> common/mpt_pkg.sv
/*
  Shared constants and types for the translation-side protection block:
  register indices and field positions, descriptor bit layout, reset values,
  the walker states and the packed carriers for request, answer and state.
  Assumes a single clock domain and the register port of the block.
*/
`default_nettype none

package mpt_pkg;

  // register index on the control port
  localparam logic [2:0] REG_XLAT_CTL = 3'h0;
  localparam logic [2:0] REG_DATA_WIN0 = 3'h1;
  localparam logic [2:0] REG_DATA_WIN1 = 3'h2;
  localparam logic [2:0] REG_INSTR_WIN0 = 3'h3;
  localparam logic [2:0] REG_INSTR_WIN1 = 3'h4;

  // translation control fields and reset value
  localparam int XC_ENABLE_BIT = 15;
  localparam int XC_PAGE8K_BIT = 14;
  localparam logic [15:0] XC_RESET = 16'h4000;

  // transparent window fields and reset value
  localparam int WIN_BASE_MSB = 31;
  localparam int WIN_BASE_LSB = 24;
  localparam int WIN_MASK_MSB = 23;
  localparam int WIN_MASK_LSB = 16;
  localparam int WIN_ENABLE_BIT = 15;
  localparam int WIN_PRIV_MSB = 14;
  localparam int WIN_PRIV_LSB = 13;
  localparam int WIN_UA1_BIT = 9;
  localparam int WIN_UA0_BIT = 8;
  localparam int WIN_CACHE_MSB = 6;
  localparam int WIN_CACHE_LSB = 5;
  localparam int WIN_WP_BIT = 2;
  localparam logic [31:0] WIN_RESET = 32'h0000_0000;

  // descriptor fields
  localparam int DSC_TYPE_MSB = 1;
  localparam int DSC_TYPE_LSB = 0;
  localparam int DSC_WP_BIT = 2;
  localparam int DSC_USED_BIT = 3;
  localparam int DSC_MOD_BIT = 4;
  localparam int DSC_CACHE_MSB = 6;
  localparam int DSC_CACHE_LSB = 5;
  localparam int DSC_SUP_BIT = 7;
  localparam int DSC_UA0_BIT = 8;
  localparam int DSC_UA1_BIT = 9;
  localparam logic [1:0] DSC_TYPE_INDIRECT = 2'h2;
  localparam logic [1:0] DSC_TYPE_INVALID = 2'h0;

  // search levels
  localparam logic [1:0] LVL_FIRST = 2'h0;
  localparam logic [1:0] LVL_PAGE = 2'h2;

  // cache modes
  localparam logic [1:0] CM_WRITETHROUGH = 2'h0;
  localparam logic [1:0] CM_COPYBACK = 2'h1;
  localparam logic [1:0] CM_INHIBIT_SER = 2'h2;
  localparam logic [1:0] CM_INHIBIT_UNSER = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_UPDATE = 3'b100
  } mpt_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] fc;
    logic write;
    logic rmw;
    logic instr;
    logic probe;
    logic flush;
  } mpt_acc_s;

  typedef struct packed {
    logic [31:0] paddr;
    logic [1:0] cache_mode;
    logic [1:0] user_attr;
    logic wp;
    logic resident;
    logic win_hit;
    logic fault;
    logic modified;
  } mpt_rsp_s;

  typedef struct packed {
    mpt_state_e state;
    logic [1:0] level;
    mpt_acc_s acc;
    logic [31:0] desc;
    logic wp_acc;
    logic [15:0] xlat_ctl;
    logic [3:0][31:0] win;
    logic [31:0] rdata;
    logic [1:0] dis_sync;
    logic rsp_valid;
    mpt_rsp_s rsp;
    logic mem_req;
    logic mem_we;
    logic mem_lock;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
  } mpt_st_s;

endpackage

`default_nettype wire

// >>> verilog/mpt_protect.sv
/*
  Translation-side protection logic of one paged memory unit pair: transparent
  windows, translation control, a descriptor search with used/modified upkeep
  and protection checks. Assumes the execution unit holds an access until it
  is taken, and that the table memory answers each request with a one-cycle
  MEM_ACK on this clock. The translation cache itself lives outside.
*/
`default_nettype none

// Operation
// R1 - lock the bus across descriptor reads and their read-modify-write updates
// R2 - finish used/modified updates before answering the access
// R3 - table descriptor gets a used-setting write only when used was clear
// R4 - read access: locked RMW sets used if clear, modified untouched
// R5 - unprotected write: plain write U+M, locked set U, or plain set M
// R6 - protected write: only used is set, locked, modified never set
// R7 - supervisor accesses walk the supervisor tree, user accesses the user tree
// R8 - user hit on supervisor-only page completes search, answers non-resident
// R9 - any write-protect in the search marks entry; writes then fault
// R10 - enable bit off passes addresses through; reset clears it
// R11 - probe and flush work whether translation is on or off
// R12 - translation off, no window: writethrough, unprotected, user attributes low
// R13 - page size bit picks 4K at 0, 8K at 1; reset picks 8K
// R14 - windows match regardless of enable bit and disable input
// R15 - window beats the search; window zero beats window one
// R16 - base compared to address bits 31..24; hits pass untranslated
// R17 - set mask bits drop the matching base bits from compare
// R18 - window enable bit turns the window on and off
// R19 - privilege field: 00 needs bit2 low, 01 needs it high, 1x ignores
// R20 - window user attribute bits driven out, not interpreted
// R21 - window cache mode field is passed on as the access cache mode
// R22 - write-protected window aborts writes and RMW as non-resident
// R23 - instruction windows serve fetches only, data windows data accesses only
module mpt_protect
  import mpt_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [2:0] CTL_SEL,
  input wire logic CTL_WR,
  input wire logic [31:0] CTL_WDATA,
  output logic [31:0] CTL_RDATA,
  input wire logic TRANSLATION_DISABLE_IN_N,
  input wire logic [31:0] SUPERVISOR_ROOT,
  input wire logic [31:0] USER_ROOT,
  input wire logic ACC_VALID,
  output logic ACC_READY,
  input wire mpt_acc_s ACC,
  output logic RSP_VALID,
  output mpt_rsp_s RSP,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_LOCK,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA
);

  mpt_st_s st;
  mpt_st_s next_st;

  function automatic logic win_match(input logic [31:0] w, input logic [31:0] la,
                                     input logic fc2);
    logic addr_ok;
    logic priv_ok;
    addr_ok = ((la[31:24] ^ w[WIN_BASE_MSB:WIN_BASE_LSB])
               & ~w[WIN_MASK_MSB:WIN_MASK_LSB]) == 8'h00; // [R16] [R17]
    priv_ok = w[WIN_PRIV_MSB] || (w[WIN_PRIV_LSB] == fc2); // [R19]
    return w[WIN_ENABLE_BIT] && addr_ok && priv_ok; // [R18]
  endfunction

  // window pair of the unit that serves this access
  logic [31:0] win_a;
  logic [31:0] win_b;
  logic hit_a;
  logic hit_b;
  logic win_hit;
  logic [31:0] win_sel;
  logic acc_take;
  logic xlat_off;

  always_comb begin
    win_a = ACC.instr ? st.win[2] : st.win[0]; // [R23]
    win_b = ACC.instr ? st.win[3] : st.win[1]; // [R23]
    hit_a = win_match(win_a, ACC.addr, ACC.fc[2]); // [R14]
    hit_b = win_match(win_b, ACC.addr, ACC.fc[2]);
    win_hit = hit_a || hit_b;
    win_sel = hit_a ? win_a : win_b; // [R15]
    acc_take = ACC_VALID && (st.state == ST_IDLE);
    xlat_off = !st.xlat_ctl[XC_ENABLE_BIT] || !st.dis_sync[1]; // [R10]
  end

  // descriptor decode on the word being returned
  logic d_used;
  logic d_mod;
  logic d_wp;
  logic d_valid;
  logic pg_wp;
  logic pg_write;
  logic sup_viol;
  logic [31:0] next_addr;

  always_comb begin
    d_used = MEM_RDATA[DSC_USED_BIT];
    d_mod = MEM_RDATA[DSC_MOD_BIT];
    d_wp = MEM_RDATA[DSC_WP_BIT];
    pg_wp = st.wp_acc || d_wp; // [R9]
    pg_write = st.acc.write || st.acc.rmw;
    sup_viol = !st.acc.fc[2] && MEM_RDATA[DSC_SUP_BIT]; // [R8]
    if (st.level == LVL_PAGE) begin
      // indirect pointers are not followed; they end the search non-resident
      d_valid = (MEM_RDATA[DSC_TYPE_MSB:DSC_TYPE_LSB] != DSC_TYPE_INVALID)
                && (MEM_RDATA[DSC_TYPE_MSB:DSC_TYPE_LSB] != DSC_TYPE_INDIRECT);
    end else begin
      d_valid = MEM_RDATA[DSC_TYPE_MSB];
    end
    if (st.level == LVL_FIRST) begin
      next_addr = {st.desc[31:9], st.acc.addr[24:18], 2'b00};
    end else if (st.xlat_ctl[XC_PAGE8K_BIT]) begin
      next_addr = {st.desc[31:7], st.acc.addr[17:13], 2'b00}; // [R13]
    end else begin
      next_addr = {st.desc[31:8], st.acc.addr[17:12], 2'b00}; // [R13]
    end
  end

  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.dis_sync = {st.dis_sync[0], TRANSLATION_DISABLE_IN_N};
    unique case (CTL_SEL)
      REG_XLAT_CTL: next_st.rdata = {16'h0000, st.xlat_ctl};
      REG_DATA_WIN0: next_st.rdata = st.win[0];
      REG_DATA_WIN1: next_st.rdata = st.win[1];
      REG_INSTR_WIN0: next_st.rdata = st.win[2];
      REG_INSTR_WIN1: next_st.rdata = st.win[3];
      default: next_st.rdata = 32'h0000_0000;
    endcase
    if (CTL_WR) begin
      unique case (CTL_SEL)
        REG_XLAT_CTL: next_st.xlat_ctl = CTL_WDATA[15:0];
        REG_DATA_WIN0: next_st.win[0] = CTL_WDATA;
        REG_DATA_WIN1: next_st.win[1] = CTL_WDATA;
        REG_INSTR_WIN0: next_st.win[2] = CTL_WDATA;
        REG_INSTR_WIN1: next_st.win[3] = CTL_WDATA;
        default: next_st.xlat_ctl = st.xlat_ctl;
      endcase
    end
    unique case (st.state)
      ST_IDLE: begin
        if (acc_take) begin
          next_st.acc = ACC;
          next_st.rsp = '0;
          next_st.rsp.paddr = ACC.addr;
          next_st.rsp.resident = 1'b1;
          next_st.wp_acc = 1'b0;
          if (ACC.flush) begin
            // nothing cached here: flush is taken and answered at once
            next_st.rsp_valid = 1'b1; // [R11]
          end else if (win_hit) begin
            next_st.rsp.win_hit = 1'b1; // [R15]
            next_st.rsp.cache_mode = win_sel[WIN_CACHE_MSB:WIN_CACHE_LSB]; // [R21]
            next_st.rsp.user_attr = {win_sel[WIN_UA1_BIT], win_sel[WIN_UA0_BIT]}; // [R20]
            next_st.rsp.wp = win_sel[WIN_WP_BIT];
            if (win_sel[WIN_WP_BIT] && (ACC.write || ACC.rmw)) begin
              next_st.rsp.fault = 1'b1; // [R22]
              next_st.rsp.resident = 1'b0; // [R22]
            end
            next_st.rsp_valid = 1'b1;
          end else if (xlat_off && !ACC.probe) begin
            next_st.rsp.cache_mode = CM_WRITETHROUGH; // [R12]
            next_st.rsp_valid = 1'b1; // [R10]
          end else begin
            next_st.level = LVL_FIRST;
            next_st.mem_addr = ACC.fc[2]
              ? {SUPERVISOR_ROOT[31:9], ACC.addr[31:25], 2'b00} // [R7]
              : {USER_ROOT[31:9], ACC.addr[31:25], 2'b00}; // [R7]
            next_st.mem_req = 1'b1;
            next_st.mem_we = 1'b0;
            next_st.mem_lock = 1'b1; // [R1]
            next_st.state = ST_FETCH; // [R11]
          end
        end
      end
      ST_FETCH: begin
        if (MEM_ACK) begin
          next_st.mem_req = 1'b0;
          next_st.desc = MEM_RDATA;
          next_st.mem_wdata = MEM_RDATA;
          if (!d_valid || ((st.level == LVL_PAGE) && sup_viol)) begin
            next_st.rsp.resident = 1'b0; // [R8]
            next_st.rsp.fault = 1'b1;
            next_st.rsp.wp = pg_wp;
            next_st.mem_lock = 1'b0;
            next_st.rsp_valid = 1'b1;
            next_st.state = ST_IDLE;
          end else if (st.level != LVL_PAGE) begin
            next_st.wp_acc = pg_wp; // [R9]
            if (!d_used) begin
              next_st.mem_wdata[DSC_USED_BIT] = 1'b1; // [R3]
              next_st.desc[DSC_USED_BIT] = 1'b1;
              next_st.mem_we = 1'b1;
              next_st.mem_req = 1'b1; // [R1]
              next_st.state = ST_UPDATE;
            end else begin
              next_st.level = st.level + 2'h1;
              next_st.state = ST_FETCH;
              next_st.mem_req = 1'b1;
            end
          end else begin
            next_st.wp_acc = pg_wp;
            next_st.rsp.wp = pg_wp; // [R9]
            next_st.rsp.fault = pg_write && pg_wp; // [R9]
            next_st.rsp.cache_mode = MEM_RDATA[DSC_CACHE_MSB:DSC_CACHE_LSB];
            next_st.rsp.user_attr = {MEM_RDATA[DSC_UA1_BIT], MEM_RDATA[DSC_UA0_BIT]};
            next_st.rsp.paddr = st.xlat_ctl[XC_PAGE8K_BIT]
              ? {MEM_RDATA[31:13], st.acc.addr[12:0]}
              : {MEM_RDATA[31:12], st.acc.addr[11:0]};
            next_st.rsp.modified = d_mod;
            next_st.mem_wdata[DSC_USED_BIT] = 1'b1;
            if (!d_used && (!pg_write || pg_wp || d_mod)) begin
              // locked read-modify-write setting only used
              next_st.mem_we = 1'b1; // [R4] [R6]
              next_st.mem_req = 1'b1;
              next_st.mem_lock = 1'b1; // [R1]
              next_st.state = ST_UPDATE;
            end else if (pg_write && !pg_wp && !d_mod) begin
              // plain write setting modified, and used when it was clear
              next_st.mem_wdata[DSC_MOD_BIT] = 1'b1; // [R5]
              next_st.rsp.modified = 1'b1;
              next_st.mem_we = 1'b1;
              next_st.mem_req = 1'b1;
              next_st.mem_lock = 1'b0; // [R5]
              next_st.state = ST_UPDATE;
            end else begin
              next_st.mem_lock = 1'b0;
              next_st.rsp_valid = 1'b1; // [R4]
              next_st.state = ST_IDLE;
            end
          end
          if (next_st.state == ST_FETCH) begin
            next_st.mem_addr = (st.level == LVL_FIRST)
              ? {MEM_RDATA[31:9], st.acc.addr[24:18], 2'b00}
              : (st.xlat_ctl[XC_PAGE8K_BIT]
                ? {MEM_RDATA[31:7], st.acc.addr[17:13], 2'b00}
                : {MEM_RDATA[31:8], st.acc.addr[17:12], 2'b00});
          end
        end
      end
      ST_UPDATE: begin
        if (MEM_ACK) begin
          next_st.mem_req = 1'b0;
          next_st.mem_we = 1'b0;
          if (st.level == LVL_PAGE) begin
            next_st.mem_lock = 1'b0;
            next_st.rsp_valid = 1'b1; // [R2]
            next_st.state = ST_IDLE;
          end else begin
            next_st.level = st.level + 2'h1;
            next_st.mem_addr = next_addr;
            next_st.mem_req = 1'b1;
            next_st.mem_lock = 1'b1; // [R1]
            next_st.state = ST_FETCH;
          end
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.xlat_ctl <= XC_RESET; // [R10] [R13]
      st.win <= {4{WIN_RESET}}; // [R18]
    end else begin
      st <= next_st;
    end
  end

  assign CTL_RDATA = st.rdata;
  assign ACC_READY = (st.state == ST_IDLE);
  assign RSP_VALID = st.rsp_valid;
  assign RSP = st.rsp;
  assign MEM_REQ = st.mem_req;
  assign MEM_WE = st.mem_we;
  assign MEM_LOCK = st.mem_lock;
  assign MEM_ADDR = st.mem_addr;
  assign MEM_WDATA = st.mem_wdata;

  fetch_locked_a: assert property ( // [R1]
    @(posedge REF_CLK) disable iff (RST)
    (MEM_REQ && !MEM_WE) |-> MEM_LOCK)
    else $error("descriptor read issued without lock");

  table_update_a: assert property ( // [R3]
    @(posedge REF_CLK) disable iff (RST)
    (st.state == ST_FETCH && MEM_ACK && st.level != LVL_PAGE && d_valid)
      |=> MEM_LOCK && (MEM_WE == !$past(d_used)) && (!MEM_WE || MEM_WDATA[DSC_USED_BIT]))
    else $error("table descriptor update is not a locked used write");

  answer_after_update_a: assert property ( // [R2]
    @(posedge REF_CLK) disable iff (RST)
    ($past(st.state) == ST_UPDATE && RSP_VALID) |-> $past(MEM_ACK))
    else $error("answer given before descriptor update completed");

  protected_write_a: assert property ( // [R6]
    @(posedge REF_CLK) disable iff (RST)
    (MEM_REQ && MEM_WE && st.level == LVL_PAGE && st.wp_acc)
      |-> MEM_LOCK && (MEM_WDATA[DSC_MOD_BIT] == st.desc[DSC_MOD_BIT]))
    else $error("protected page updated by unlocked write");

  xlat_off_pass_a: assert property ( // [R10]
    @(posedge REF_CLK) disable iff (RST)
    (acc_take && !win_hit && !ACC.flush && !ACC.probe && xlat_off)
      |=> RSP_VALID && RSP.paddr == $past(ACC.addr) && RSP.cache_mode == CM_WRITETHROUGH
          && RSP.user_attr == 2'h0 && !RSP.wp && !RSP.fault)
    else $error("pass-through answer wrong with translation off");

  window_prio_a: assert property ( // [R15]
    @(posedge REF_CLK) disable iff (RST)
    (acc_take && hit_a && !ACC.flush)
      |=> RSP_VALID && RSP.win_hit
          && RSP.cache_mode == $past(win_a[WIN_CACHE_MSB:WIN_CACHE_LSB]))
    else $error("window zero did not take priority");

  window_wp_a: assert property ( // [R22]
    @(posedge REF_CLK) disable iff (RST)
    (acc_take && win_hit && !ACC.flush && win_sel[WIN_WP_BIT] && ACC.write)
      |=> RSP.fault && !RSP.resident)
    else $error("write into protected window not aborted");

  sup_page_a: assert property ( // [R8]
    @(posedge REF_CLK) disable iff (RST)
    (st.state == ST_FETCH && MEM_ACK && st.level == LVL_PAGE && sup_viol)
      |=> RSP_VALID && !RSP.resident && !MEM_REQ)
    else $error("user access to supervisor page not refused");

  mem_hold_a: assert property ( // [R1]
    @(posedge REF_CLK) disable iff (RST)
    (MEM_REQ && !MEM_ACK) |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_LOCK))
    else $error("memory request dropped before acknowledge");

  // page descriptor upkeep checked one cycle after the edge that returns the page word
  read_update_a: assert property ( // [R4]
    @(posedge REF_CLK) disable iff (RST)
    (st.state == ST_FETCH && MEM_ACK && st.level == LVL_PAGE && d_valid && !sup_viol
      && !pg_write)
      |=> (MEM_WE == !$past(d_used))
          && (!MEM_WE || (MEM_LOCK && (MEM_WDATA[DSC_MOD_BIT] == $past(d_mod)))))
    else $error("read access page update wrong");

  write_modify_a: assert property ( // [R5]
    @(posedge REF_CLK) disable iff (RST)
    (st.state == ST_FETCH && MEM_ACK && st.level == LVL_PAGE && d_valid && !sup_viol
      && pg_write && !pg_wp && !d_mod)
      |=> MEM_REQ && MEM_WE && !MEM_LOCK && MEM_WDATA[DSC_MOD_BIT] && MEM_WDATA[DSC_USED_BIT])
    else $error("unprotected write did not set modified");

  prot_fault_a: assert property ( // [R9]
    @(posedge REF_CLK) disable iff (RST)
    (st.state == ST_FETCH && MEM_ACK && st.level == LVL_PAGE && d_valid && !sup_viol
      && pg_write && pg_wp)
      |=> RSP.wp && RSP.fault && (RSP.modified == $past(d_mod)))
    else $error("write to protected page not faulted");

  window_attr_a: assert property ( // [R20]
    @(posedge REF_CLK) disable iff (RST)
    (acc_take && win_hit && !ACC.flush)
      |=> RSP.paddr == $past(ACC.addr) && RSP.user_attr[1] == $past(win_sel[WIN_UA1_BIT])
          && RSP.user_attr[0] == $past(win_sel[WIN_UA0_BIT]))
    else $error("window answer attributes wrong");

endmodule

`default_nettype wire

// >>> verif/mpt_mem_model.sv
/*
  Table memory model for the protection block: answers each request with a
  one-cycle ack, at once or after three wait cycles, and counts writes.
  Assumes the requester holds request lines stable until ack.
*/
`default_nettype none

module mpt_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic we,
  input wire logic lock,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic slow,
  output logic ack,
  output logic [31:0] rdata,
  output logic [7:0] wr_n,
  output logic [7:0] lk_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_c;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      rdata <= 32'h0;
      wr_n <= 8'h0;
      lk_n <= 8'h0;
      wait_c <= 2'h0;
    end else begin
      ack <= 1'b0;
      // data line is not held past the ack cycle
      rdata <= ~rdata;
      if (req && !ack) begin
        if (slow && wait_c != 2'h3) begin
          wait_c <= wait_c + 2'h1;
        end else begin
          wait_c <= 2'h0;
          ack <= 1'b1;
          if (we) begin
            mem[addr] = wdata;
            wr_n <= wr_n + 8'h1;
            if (lock) begin
              lk_n <= lk_n + 8'h1;
            end
          end else begin
            rdata <= mem.exists(addr) ? mem[addr] : 32'h0;
          end
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> verif/mpt_protect_tb.sv
/*
  Testbench for the protection block: register and access tasks, windows,
  descriptor searches with used/modified upkeep and protection faults.
  Assumes the table memory model beside the design.
*/
`default_nettype none

module mpt_protect_tb;
  import mpt_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] K_RD = 5'h00;
  localparam logic [4:0] K_WR = 5'h10;
  localparam logic [4:0] K_RMW = 5'h08;
  localparam logic [4:0] K_FETCH = 5'h04;
  localparam logic [4:0] K_PROBE = 5'h02;
  localparam logic [4:0] K_FLUSH = 5'h01;
  logic ref_clk, rst, ctl_wr, dis_n, acc_valid, acc_ready, rsp_valid;
  logic mem_req, mem_we, mem_lock, mem_ack, slow;
  logic [2:0] ctl_sel;
  logic [31:0] ctl_wdata, ctl_rdata, sup_root, usr_root, mem_addr, mem_wdata, mem_rdata;
  logic [7:0] wr_n, lk_n, w0, l0;
  mpt_acc_s acc;
  mpt_rsp_s rsp, r;
  int err_count, comparisons;

  mpt_protect mpt_protect_i (.REF_CLK(ref_clk), .RST(rst), .CTL_SEL(ctl_sel), .CTL_WR(ctl_wr),
    .CTL_WDATA(ctl_wdata), .CTL_RDATA(ctl_rdata), .TRANSLATION_DISABLE_IN_N(dis_n),
    .SUPERVISOR_ROOT(sup_root), .USER_ROOT(usr_root), .ACC_VALID(acc_valid),
    .ACC_READY(acc_ready), .ACC(acc), .RSP_VALID(rsp_valid), .RSP(rsp), .MEM_REQ(mem_req),
    .MEM_WE(mem_we), .MEM_LOCK(mem_lock), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata));
  mpt_mem_model mpt_mem_model_i (.clk(ref_clk), .rst(rst), .req(mem_req), .we(mem_we),
    .lock(mem_lock), .addr(mem_addr), .wdata(mem_wdata), .slow(slow), .ack(mem_ack),
    .rdata(mem_rdata), .wr_n(wr_n), .lk_n(lk_n));

  always #5 ref_clk = ~ref_clk;

  task stop_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask

  task reg_wr(input logic [2:0] s, input logic [31:0] d);
    @(negedge ref_clk);
    ctl_sel = s;
    ctl_wdata = d;
    ctl_wr = 1'b1;
    @(negedge ref_clk);
    ctl_wr = 1'b0;
  endtask

  task reg_rd(input logic [2:0] s, input logic [31:0] e);
    @(negedge ref_clk);
    ctl_sel = s;
    @(negedge ref_clk);
    chk("ctl_rdata", e, ctl_rdata);
  endtask

  task go(input logic [31:0] a, input logic [2:0] fc, input logic [4:0] k);
    int i;
    @(negedge ref_clk);
    acc = {a, fc, k};
    acc_valid = 1'b1;
    i = 0;
    while (acc_ready !== 1'b1 && i < 100) begin
      @(negedge ref_clk);
      i++;
    end
    if (acc_ready !== 1'b1) begin
      chk("acc_ready", 32'h1, 32'h0);
    end
    @(negedge ref_clk);
    acc_valid = 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 200) begin
      @(negedge ref_clk);
      i++;
    end
    if (rsp_valid !== 1'b1) begin
      chk("rsp_valid", 32'h1, 32'h0);
      stop_test;
    end
    r = rsp;
  endtask

  task ex(input logic [31:0] pa, input logic [1:0] cm, input logic [1:0] ua,
          input logic hit, input logic res, input logic flt);
    chk("paddr", pa, r.paddr);
    chk("cache_mode", {30'h0, cm}, {30'h0, r.cache_mode});
    chk("user_attr", {30'h0, ua}, {30'h0, r.user_attr});
    chk("win_hit", {31'h0, hit}, {31'h0, r.win_hit});
    chk("resident", {31'h0, res}, {31'h0, r.resident});
    chk("fault", {31'h0, flt}, {31'h0, r.fault});
  endtask

  task upd(input logic [31:0] a, input logic [4:0] k, input logic [31:0] da,
           input logic [31:0] dv, input logic [7:0] nw, input logic [7:0] nl);
    w0 = wr_n;
    l0 = lk_n;
    go(a, 3'h1, k);
    chk("descriptor", dv, mpt_mem_model_i.mem[da]);
    chk("writes", {24'h0, nw}, {24'h0, wr_n - w0});
    chk("locked_writes", {24'h0, nl}, {24'h0, lk_n - l0});
  endtask

  function automatic logic [31:0] win(input logic [7:0] b, input logic [7:0] m,
      input logic [1:0] p, input logic [1:0] ua, input logic [1:0] cm, input logic wp);
    return {b, m, 1'b1, p, 3'h0, ua, 1'b0, cm, 2'h0, wp, 2'h0};
  endfunction

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {ctl_sel, ctl_wr, ctl_wdata, acc_valid, slow} = '0;
    acc = '0;
    dis_n = 1'b1;
    sup_root = 32'h0000_5000;
    usr_root = 32'h0000_1000;
    err_count = 0;
    comparisons = 0;
    mpt_mem_model_i.mem[32'h1000] = 32'h0000_2003;
    mpt_mem_model_i.mem[32'h2000] = 32'h0000_3002;
    mpt_mem_model_i.mem[32'h3000] = 32'h0040_1001;
    mpt_mem_model_i.mem[32'h3004] = 32'h0050_0005;
    mpt_mem_model_i.mem[32'h3008] = 32'h0060_0081;
    mpt_mem_model_i.mem[32'h300C] = 32'h0070_0001;
    mpt_mem_model_i.mem[32'h3010] = 32'h0070_2011;
    mpt_mem_model_i.mem[32'h5000] = 32'h0000_6003;
    mpt_mem_model_i.mem[32'h6000] = 32'h0000_7002;
    mpt_mem_model_i.mem[32'h7000] = 32'h0080_0019;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    reg_rd(REG_XLAT_CTL, 32'h0000_4000);
    reg_rd(REG_DATA_WIN0, 32'h0);
    reg_wr(3'h5, 32'hFFFF_FFFF);
    reg_rd(3'h5, 32'h0);
    go(32'h0123_4567, 3'h1, K_WR);
    ex(32'h0123_4567, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0);
    chk("wp", 32'h0, {31'h0, r.wp});
    for (int c = 0; c < 4; c++) begin
      reg_wr(REG_DATA_WIN0, win(8'h12, 8'h01, 2'h2, 2'h2, c[1:0], 1'b0));
      go(32'h1300_0010, 3'h1, K_RD);
      ex(32'h1300_0010, c[1:0], 2'h2, 1'b1, 1'b1, 1'b0);
    end
    go(32'h1400_0010, 3'h1, K_RD);
    chk("win_hit", 32'h0, {31'h0, r.win_hit});
    for (int p = 0; p < 8; p++) begin
      reg_wr(REG_DATA_WIN0, win(8'h12, 8'h00, p[2:1], 2'h0, 2'h0, 1'b0));
      go(32'h1200_0000, {p[0], 2'h1}, K_RD);
      chk("win_hit", {31'h0, p[2] | (p[1] == p[0])}, {31'h0, r.win_hit});
    end
    reg_wr(REG_DATA_WIN0, win(8'h12, 8'h01, 2'h2, 2'h2, 2'h0, 1'b0));
    go(32'h1300_0010, 3'h1, K_FETCH);
    chk("win_hit", 32'h0, {31'h0, r.win_hit});
    reg_wr(REG_INSTR_WIN1, win(8'h13, 8'h00, 2'h2, 2'h0, 2'h1, 1'b0));
    go(32'h1300_0010, 3'h1, K_FETCH);
    ex(32'h1300_0010, 2'h1, 2'h0, 1'b1, 1'b1, 1'b0);
    reg_wr(REG_DATA_WIN1, win(8'h13, 8'h00, 2'h2, 2'h1, 2'h3, 1'b0));
    go(32'h1300_0010, 3'h1, K_RD);
    ex(32'h1300_0010, 2'h0, 2'h2, 1'b1, 1'b1, 1'b0);
    reg_wr(REG_DATA_WIN0, 32'h0);
    go(32'h1300_0010, 3'h1, K_RD);
    ex(32'h1300_0010, 2'h3, 2'h1, 1'b1, 1'b1, 1'b0);
    reg_wr(REG_DATA_WIN1, win(8'h13, 8'h00, 2'h2, 2'h1, 2'h3, 1'b1));
    go(32'h1300_0010, 3'h1, K_RD);
    chk("fault", 32'h0, {31'h0, r.fault});
    go(32'h1300_0010, 3'h5, K_WR);
    chk("fault", 32'h1, {31'h0, r.fault});
    go(32'h1300_0010, 3'h1, K_RMW);
    chk("fault", 32'h1, {31'h0, r.fault});
    reg_wr(REG_XLAT_CTL, 32'h0000_C000);
    dis_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    go(32'h1300_0010, 3'h1, K_RD);
    ex(32'h1300_0010, 2'h3, 2'h1, 1'b1, 1'b1, 1'b0);
    upd(32'h0000_0123, K_RD, 32'h3000, 32'h0040_1001, 8'h0, 8'h0);
    chk("paddr", 32'h0000_0123, r.paddr);
    dis_n = 1'b1;
    slow = 1'b1;
    repeat (3) @(negedge ref_clk);
    upd(32'h0000_0123, K_RD, 32'h3000, 32'h0040_1009, 8'h3, 8'h3);
    ex(32'h0040_0123, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0);
    chk("tbl_used", 32'h0000_200B, mpt_mem_model_i.mem[32'h1000]);
    slow = 1'b0;
    upd(32'h0000_0123, K_RD, 32'h3000, 32'h0040_1009, 8'h0, 8'h0);
    upd(32'h0000_0123, K_WR, 32'h3000, 32'h0040_1019, 8'h1, 8'h0);
    chk("modified", 32'h1, {31'h0, r.modified});
    upd(32'h0000_6000, K_WR, 32'h300C, 32'h0070_0019, 8'h1, 8'h0);
    upd(32'h0000_8000, K_WR, 32'h3010, 32'h0070_2019, 8'h1, 8'h1);
    upd(32'h0000_2000, K_WR, 32'h3004, 32'h0050_000D, 8'h1, 8'h1);
    chk("modified", 32'h0, {31'h0, r.modified});
    chk("wp", 32'h1, {31'h0, r.wp});
    chk("fault", 32'h1, {31'h0, r.fault});
    upd(32'h0000_4000, K_RD, 32'h3008, 32'h0060_0081, 8'h0, 8'h0);
    chk("resident", 32'h0, {31'h0, r.resident});
    go(32'h0000_0123, 3'h5, K_RD);
    chk("paddr", 32'h0080_0123, r.paddr);
    reg_wr(REG_XLAT_CTL, 32'h0000_8000);
    reg_rd(REG_XLAT_CTL, 32'h0000_8000);
    go(32'h0000_0123, 3'h1, K_RD);
    chk("paddr", 32'h0040_1123, r.paddr);
    reg_wr(REG_XLAT_CTL, 32'h0);
    go(32'h0000_0123, 3'h1, K_PROBE);
    chk("paddr", 32'h0040_1123, r.paddr);
    chk("resident", 32'h1, {31'h0, r.resident});
    go(32'h0000_0123, 3'h1, K_FLUSH);
    chk("fault", 32'h0, {31'h0, r.fault});
    stop_test;
  end
endmodule

`default_nettype wire
